// [rtl/hub_host_channels.sv]
// host channel register bank of the sensor hub
`timescale 1ns/100ps
module hub_host_channels (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // host register port, byte wide
    input  wire logic [6:0]       reg_addr_i,
    input  wire logic             reg_wr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_rd_i,
    output logic [7:0]            reg_rdata_o,
    output logic                  reg_rvalid_o,
    output logic                  cmd_space_o,
    // command stream to firmware
    output logic [7:0]            cmd_byte_o,
    output logic                  cmd_first_o,
    output logic                  cmd_valid_o,
    input  wire logic             cmd_ready_i,
    // output channels from firmware, index 0 wake, 1 non-wake, 2 status
    input  wire logic [2:0]       out_load_i,
    input  wire logic [2:0][15:0] out_len_i,
    input  wire logic [2:0][7:0]  out_data_i,
    input  wire logic [2:0]       out_valid_i,
    output logic [2:0]            out_take_o,
    output logic [3:0]            out_abort_o,
    // chip level controls and status
    output logic                  boot_speed_limit_o,
    output logic                  fault_clear_o,
    output logic                  ts_select_o,
    output logic                  async_status_o,
    output logic                  app_processor_asleep_o,
    output logic [3:0]            chan_pending_o,
    output logic                  host_irq_o
);
    import hub_pkg::*;

    // ************************************************************
    // state
    // ************************************************************

    // whole block state in one packed struct
    typedef struct packed {
        logic [7:0]  chip_ctrl;   // chip behaviour control, stored bits
        logic [7:0]  link_ctrl;   // host link control, stored bits
        logic [7:0]  rdata;       // read data to host
        logic        rvalid;      // read answer strobe
        logic        fault_clr;   // fault log clear pulse
        logic [3:0]  abort_rise;  // abort edge pulses to firmware
        logic        hdr;         // parser inside packet header
        logic [1:0]  hidx;        // header byte index
        logic [7:0]  len_lo;      // low byte of packet length
        logic [15:0] remain;      // parameter bytes still to come
        logic [7:0]  cmd_byte;    // command output stage
        logic        cmd_first;   // byte opens a packet
        logic        cmd_valid;   // output stage holds a byte
        logic [3:0]  pending;     // per channel transfer pending
        logic        irq;         // host interrupt
        logic        space;       // command fifo has room
    } bank_t;

    bank_t st, next_st;

    // fifo and channel wiring
    logic                      fifo_in_ready;  // command fifo can take a byte
    logic                      fifo_out_valid; // command fifo holds a byte
    logic                      fifo_pop;       // move a byte to the output stage
    logic [CMD_FIFO_WIDTH-1:0] fifo_out;       // {first, byte}
    logic                      cmd_wr;         // accepted command byte
    logic                      cmd_first_now;  // accepted byte opens a packet
    logic                      abort0;         // command channel abort level
    logic [2:0]                ch_rd;          // host read strobe per output channel
    logic [2:0][7:0]           ch_byte;        // byte offered per output channel
    logic [2:0]                ch_pend;        // session open per output channel

    // ************************************************************
    // command input channel
    // ************************************************************

    // host writes to the command port only; full fifo drops the byte
    assign cmd_wr = reg_wr_i && reg_addr_i == command_input_port && fifo_in_ready
                    && !abort0;
    assign abort0 = st.link_ctrl[LINK_ABORT_LSB];
    assign cmd_first_now = st.hdr && st.hidx == 2'd0;
    // output stage refills whenever empty or being drained
    assign fifo_pop = fifo_out_valid && (!st.cmd_valid || cmd_ready_i) && !abort0;

    // command fifo; the firmware drain can stall so it really fills
    hub_fifo #(
        .WIDTH (CMD_FIFO_WIDTH),
        .DEPTH (CMD_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .flush_i     (abort0),
        .in_valid_i  (cmd_wr),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({cmd_first_now, reg_wdata_i}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out)
    );

    // ************************************************************
    // output channels
    // ************************************************************

    // host read strobes, one per readable channel port
    assign ch_rd[0] = reg_rd_i && reg_addr_i == wake_fifo_output_port;
    assign ch_rd[1] = reg_rd_i && reg_addr_i == nonwake_fifo_output_port;
    assign ch_rd[2] = reg_rd_i && reg_addr_i == status_debug_output_port;

    // one streamer per channel, aborted by its link control bit
    for (genvar g = 0; g < 3; g++) begin : g_chan
        hub_out_channel u_chan (
            .clk_i        (clk_i),
            .sys_rst_i    (sys_rst_i),
            .load_i       (out_load_i[g]),
            .len_i        (out_len_i[g]),
            .data_i       (out_data_i[g]),
            .data_valid_i (out_valid_i[g]),
            .take_o       (out_take_o[g]),
            .abort_i      (st.link_ctrl[LINK_ABORT_LSB + g + 1]),
            .rd_i         (ch_rd[g]),
            .byte_o       (ch_byte[g]),
            .pending_o    (ch_pend[g])
        );
    end

    // ************************************************************
    // next state
    // ************************************************************

    // register writes, read answers, parser, output stage, interrupt
    always_comb begin
        next_st            = st;
        next_st.rvalid     = 1'b0;
        next_st.fault_clr  = 1'b0;
        next_st.abort_rise = 4'h0;

        // register writes; reserved bits are masked off
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                chip_behaviour_control: begin
                    next_st.chip_ctrl = reg_wdata_i & CHIP_CTRL_MASK;
                    next_st.fault_clr = reg_wdata_i[CHIP_FAULT_CLEAR_BIT];
                end
                host_link_control: begin
                    // abort bits are levels; the host clears them itself
                    next_st.link_ctrl  = reg_wdata_i & LINK_CTRL_MASK;
                    next_st.abort_rise = reg_wdata_i[3:0]
                                         & ~st.link_ctrl[3:0];
                end
                default: ;  // channel ports and unmapped offsets store nothing
            endcase
        end

        // read answers, one cycle after the strobe
        if (reg_rd_i) begin
            next_st.rvalid = 1'b1;
            unique case (reg_addr_i)
                wake_fifo_output_port:    next_st.rdata = ch_byte[0];
                nonwake_fifo_output_port: next_st.rdata = ch_byte[1];
                status_debug_output_port: next_st.rdata = ch_byte[2];
                chip_behaviour_control:   next_st.rdata = st.chip_ctrl;
                host_link_control:        next_st.rdata = st.link_ctrl;
                // write-only command port, reserved slot and the rest read zero
                default:                  next_st.rdata = 8'h00;
            endcase
        end

        // packet framing: two code bytes, two length bytes, then parameters
        if (cmd_wr) begin
            if (st.hdr) begin
                next_st.hidx = st.hidx + 2'd1;
                if (st.hidx == 2'd2) begin
                    next_st.len_lo = reg_wdata_i;
                end
                if (st.hidx == 2'(CMD_HDR_BYTES - 1)) begin
                    // length zero means a bare header; next byte opens a packet
                    next_st.remain = {reg_wdata_i, st.len_lo};
                    next_st.hdr    = ({reg_wdata_i, st.len_lo} == 16'h0000);
                end
            end else begin
                next_st.remain = st.remain - 16'h0001;
                if (st.remain == 16'h0001) begin
                    next_st.hdr  = 1'b1;
                    next_st.hidx = 2'd0;
                end
            end
        end

        // command output stage towards firmware
        if (fifo_pop) begin
            next_st.cmd_valid = 1'b1;
            next_st.cmd_byte  = fifo_out[7:0];
            next_st.cmd_first = fifo_out[8];
        end else if (cmd_ready_i) begin
            next_st.cmd_valid = 1'b0;
        end

        // command abort drops the partial packet and restarts framing
        if (abort0) begin
            next_st.hdr       = 1'b1;
            next_st.hidx      = 2'd0;
            next_st.remain    = 16'h0000;
            next_st.cmd_valid = 1'b0;
        end

        next_st.space = fifo_in_ready && !abort0;

        // pending flags follow the live session of each channel
        next_st.pending = {ch_pend, st.cmd_valid | fifo_out_valid};

        // interrupt holds while any enabled output channel still has a transfer
        next_st.irq = ch_pend[0]
                      | (ch_pend[1] & ~st.link_ctrl[LINK_ASLEEP_BIT])
                      // sync mode announces status packets, async leaves polling
                      | (ch_pend[2] & ~st.link_ctrl[LINK_ASYNC_BIT]);
    end

    // ************************************************************
    // state register
    // ************************************************************

    // single register for all block state
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st           <= '0;
            st.chip_ctrl <= CHIP_CTRL_RESET;
            st.link_ctrl <= LINK_CTRL_RESET;
            st.hdr       <= 1'b1;
            st.space     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs, all from flip-flops
    // ************************************************************
    assign reg_rdata_o            = st.rdata;
    assign reg_rvalid_o           = st.rvalid;
    assign cmd_space_o            = st.space;
    assign cmd_byte_o             = st.cmd_byte;
    assign cmd_first_o            = st.cmd_first;
    assign cmd_valid_o            = st.cmd_valid;
    assign out_abort_o            = st.abort_rise;
    assign boot_speed_limit_o     = st.chip_ctrl[CHIP_SPEED_LIMIT_BIT];
    assign fault_clear_o          = st.fault_clr;
    assign ts_select_o            = st.link_ctrl[LINK_TS_SEL_BIT];
    assign async_status_o         = st.link_ctrl[LINK_ASYNC_BIT];
    assign app_processor_asleep_o = st.link_ctrl[LINK_ASLEEP_BIT];
    assign chan_pending_o         = st.pending;
    assign host_irq_o             = st.irq;

endmodule : hub_host_channels

// [rtl/hub_pkg.sv]
// constants and types shared by the sensor hub host channel block
package hub_pkg;

    // ************************************************************
    // register offsets on the host port
    // ************************************************************
    localparam logic [6:0] command_input_port       = 7'h00;
    localparam logic [6:0] wake_fifo_output_port    = 7'h01;
    localparam logic [6:0] nonwake_fifo_output_port = 7'h02;
    localparam logic [6:0] status_debug_output_port = 7'h03;
    localparam logic [6:0] unused_slot              = 7'h04;
    localparam logic [6:0] chip_behaviour_control   = 7'h05;
    localparam logic [6:0] host_link_control        = 7'h06;

    // ************************************************************
    // field positions, masks and reset values
    // ************************************************************
    localparam int         CHIP_SPEED_LIMIT_BIT = 0;     // boot speed limit
    localparam int         CHIP_FAULT_CLEAR_BIT = 1;     // action bit, reads zero
    localparam logic [7:0] CHIP_CTRL_MASK       = 8'h01; // stored bits only
    localparam logic [7:0] CHIP_CTRL_RESET      = 8'h00;
    localparam int         LINK_ABORT_LSB       = 0;     // abort bits 0..3
    localparam int         LINK_ASLEEP_BIT      = 4;     // app_processor_asleep
    localparam int         LINK_TS_SEL_BIT      = 6;     // timestamp source select
    localparam int         LINK_ASYNC_BIT       = 7;     // status channel async mode
    localparam logic [7:0] LINK_CTRL_MASK       = 8'hdf; // bit 5 reserved
    localparam logic [7:0] LINK_CTRL_RESET      = 8'h00;

    // ************************************************************
    // packet framing and buffering
    // ************************************************************
    localparam int         CMD_HDR_BYTES   = 4;          // code (2) + length (2)
    localparam int         CMD_FIFO_DEPTH  = 8;          // words in the command fifo
    localparam int         CMD_FIFO_WIDTH  = 9;          // {first flag, byte}

    // output channel session states
    typedef enum logic [1:0] {
        CH_IDLE,
        CH_HDR_LO,
        CH_HDR_HI,
        CH_BODY
    } chan_state_t;

endpackage : hub_pkg

// [rtl/hub_fifo.sv]
// flip-flop fifo with valid/ready on both sides and a flush input
`timescale 1ns/100ps
module hub_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             flush_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // whole fifo state in one packed struct
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage words
        logic [AW-1:0]               wr;    // write index
        logic [AW-1:0]               rd;    // read index
        logic [AW:0]                 cnt;   // words held
    } fifo_t;

    fifo_t st, next_st;
    logic  push, pop;

    assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = st.mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer and count update; flush wins over both sides
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr         = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + AW'(1);
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + AW'(1);
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            next_st.wr  = '0;
            next_st.rd  = '0;
            next_st.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : hub_fifo

// [rtl/hub_out_channel.sv]
// one output channel: two-byte length header, then payload bytes
`timescale 1ns/100ps
module hub_out_channel (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // firmware side
    input  wire logic        load_i,
    input  wire logic [15:0] len_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        data_valid_i,
    output logic             take_o,
    // host side
    input  wire logic        abort_i,
    input  wire logic        rd_i,
    output logic [7:0]       byte_o,
    output logic             pending_o
);
    import hub_pkg::*;

    // channel state in one packed struct
    typedef struct packed {
        chan_state_t ph;      // session phase
        logic [15:0] len;     // payload length of this session
        logic [15:0] remain;  // payload bytes still to go
        logic        take;    // byte consumed, one-cycle pulse
    } chan_t;

    chan_t st, next_st;

    // byte presented to the host; idle reads zero
    always_comb begin
        unique case (st.ph)
            CH_IDLE:   byte_o = 8'h00;
            CH_HDR_LO: byte_o = st.len[7:0];
            CH_HDR_HI: byte_o = st.len[15:8];
            CH_BODY:   byte_o = data_valid_i ? data_i : 8'h00; // underrun reads zero
        endcase
    end

    assign take_o    = st.take;
    assign pending_o = (st.ph != CH_IDLE);

    // session sequencing
    always_comb begin
        next_st      = st;
        next_st.take = 1'b0;
        if (abort_i) begin
            // ends the session only; firmware keeps its data and reloads later
            next_st.ph     = CH_IDLE;
            next_st.remain = '0;
        end else begin
            unique case (st.ph)
                CH_IDLE: begin
                    if (load_i && len_i != 16'h0000) begin
                        next_st.ph     = CH_HDR_LO;
                        next_st.len    = len_i;
                        next_st.remain = len_i;
                    end
                end
                CH_HDR_LO: if (rd_i) next_st.ph = CH_HDR_HI;
                CH_HDR_HI: if (rd_i) next_st.ph = CH_BODY;
                CH_BODY: begin
                    if (rd_i) begin
                        next_st.take   = data_valid_i;
                        next_st.remain = st.remain - 16'h0001;
                        if (st.remain == 16'h0001) next_st.ph = CH_IDLE;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '{ph: CH_IDLE, len: 16'h0000, remain: 16'h0000, take: 1'b0};
        end else begin
            st <= next_st;
        end
    end

endmodule : hub_out_channel

// [dv/hub_host_channels_checker.sv]
// concurrent checks on the ports of the host channel register bank
`timescale 1ns/100ps
module hub_host_channels_checker (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // register port
    input  wire logic [6:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic       reg_rvalid_o,
    // controls and status
    input  wire logic       boot_speed_limit_o,
    input  wire logic       fault_clear_o,
    input  wire logic       async_status_o,
    input  wire logic       app_processor_asleep_o,
    input  wire logic [3:0] chan_pending_o,
    input  wire logic [3:0] out_abort_o,
    input  wire logic       host_irq_o,
    input  wire logic       cmd_valid_o
);
    // one domain, so one clocking and one disable
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic w5;  // write strobe on chip control
    logic w6;  // write strobe on host link control
    assign w5 = reg_wr_i && (reg_addr_i == 7'h05);
    assign w6 = reg_wr_i && (reg_addr_i == 7'h06);
    AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe got no answer");
    AST_UNMAPPED_ZERO: assert property (reg_rd_i && (reg_addr_i == 7'h00 || reg_addr_i > 7'h06) |=> reg_rdata_o == 8'h00)
        else $error("write-only or unmapped read not zero");
    AST_SPEED: assert property (w5 |=> boot_speed_limit_o == $past(reg_wdata_i[0]))
        else $error("speed limit level wrong");
    AST_CLEAR: assert property (w5 && reg_wdata_i[1] |=> fault_clear_o)
        else $error("fault clear pulse missing");
    AST_CLEAR_ONLY: assert property (!(w5 && reg_wdata_i[1]) |=> !fault_clear_o)
        else $error("fault clear without cause");
    AST_ASLEEP: assert property (w6 |=> app_processor_asleep_o == $past(reg_wdata_i[4]))
        else $error("asleep flag wrong");
    AST_ASYNC: assert property (w6 |=> async_status_o == $past(reg_wdata_i[7]))
        else $error("status mode wrong");
    AST_ABORT: assert property (w6 && reg_wdata_i[2] |-> ##3 !chan_pending_o[2])
        else $error("abort left channel pending");
    AST_ABORT_ONLY: assert property (!w6 |=> out_abort_o == 4'h0)
        else $error("abort pulse without a link control write");
    AST_IRQ_WAKE: assert property (chan_pending_o[1] |-> host_irq_o)
        else $error("wake pending without interrupt");
    AST_IRQ_IDLE: assert property (chan_pending_o[3:1] == 3'h0 |-> !host_irq_o)
        else $error("interrupt with nothing pending");
    // main scenarios reached
    cover property (host_irq_o);
    cover property (fault_clear_o);
    cover property (cmd_valid_o);
endmodule : hub_host_channels_checker
bind hub_host_channels hub_host_channels_checker chk (.*);

// [dv/host_model.sv]
// host processor model: byte strobe register master
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic       clk_i,
    // register port
    output logic [6:0]      reg_addr_o = 7'h00,
    output logic            reg_wr_o = 1'b0,
    output logic [7:0]      reg_wdata_o = 8'h00,
    output logic            reg_rd_o = 1'b0,
    input  wire logic [7:0] reg_rdata_i
);
    // one write strobe to offset a; command bytes and control register writes both go through here
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
    endtask : wr
    // read: strobe for one edge, data taken at the edge where the answer stands
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_i);
        reg_rd_o   <= 1'b0;
        @(posedge clk_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : host_model

// [dv/test_hub_host_channels.sv]
// self-checking bench of the host channel register bank
`timescale 1ns/100ps
module test_hub_host_channels;
    import hub_pkg::*;
    logic             clk_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic [6:0]       addr;
    logic             wr, rd, rvalid, space, first, cvalid, irq;
    logic             cready = 1'b0;
    logic [7:0]       wdata, rdata, got, cbyte, d;
    logic [2:0]       load = 3'h0, take;
    logic [2:0]       vld = 3'h7;
    logic [2:0][15:0] len = '0;
    logic [2:0][7:0]  dat = '0;
    logic [3:0]       pend;
    logic [7:0]       b [10];
    logic [8:0]       rx [$];
    integer           num_errors = 0, tests_run = 0, seed = 32'h36e0, cycles = 0, i;
    host_model host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
        .reg_rd_o(rd), .reg_rdata_i(rdata));
    hub_host_channels dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .cmd_space_o(space), .cmd_byte_o(cbyte), .cmd_first_o(first),
        .cmd_valid_o(cvalid), .cmd_ready_i(cready), .out_load_i(load), .out_len_i(len),
        .out_data_i(dat), .out_valid_i(vld), .out_take_o(take), .out_abort_o(),
        .boot_speed_limit_o(), .fault_clear_o(), .ts_select_o(), .async_status_o(),
        .app_processor_asleep_o(), .chan_pending_o(pend), .host_irq_o(irq));
    always #10 clk_i = ~clk_i;
    // firmware side: next payload byte after a take; command stream captured
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (load[0]) dat[0] <= b[8];
        if (load[2]) dat[2] <= 8'ha5;
        if (take[0]) dat[0] <= b[9];
        if (cvalid && cready) rx.push_back({first, cbyte});
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end
    // chip control read back: only the speed limit bit is stored
    function automatic logic [7:0] exp_chip(input logic [7:0] v);
        return {7'h00, v[0]};
    endfunction : exp_chip
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] a);
        tests_run = tests_run + 1;
        if (a !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, a);
        end
    endtask : check
    // firmware starts a session of n bytes on channel c
    task automatic fw_load(input int c, input logic [15:0] n);
        @(posedge clk_i);
        load[c] <= 1'b1;
        len[c]  <= n;
        @(posedge clk_i);
        load[c] <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : fw_load
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    initial begin
        for (i = 0; i < 10; i++) b[i] = $random(seed);
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // idle channels, write-only, unmapped and control reset values all read zero
        foreach (b[i]) if (i < 7) begin
            host.rd((i == 6) ? 7'h10 : (i > 3) ? i[6:0] + 7'h01 : i[6:0], got);
            check("idle read", 8'h00, got);
        end
        $display("test reset values done");
        for (i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'hff : $random(seed);
            host.wr(7'h05, d);
            host.rd(7'h05, got);
            check("chip control", exp_chip(d), got);
        end
        host.wr(7'h06, 8'hf0);
        host.rd(7'h06, got);
        check("link control", 8'hd0, got);
        $display("test control registers done");
        fw_load(1, 16'h0001);
        check("asleep irq", 1'b0, irq);
        host.wr(7'h06, 8'h80);
        repeat (3) @(posedge clk_i);
        check("awake irq", 1'b1, irq);
        host.wr(7'h06, 8'h84);
        repeat (4) @(posedge clk_i);
        check("abort pending", 4'h0, pend);
        host.wr(7'h06, 8'h10);
        $display("test sleep and abort done");
        fw_load(0, 16'h0002);
        check("wake irq", 1'b1, irq);
        foreach (b[i]) if (i < 5) begin
            host.rd(7'h01, got);
            check("wake read", (i == 0) ? 8'h02 : (i == 2) ? b[8] : (i == 3) ? b[9] : 8'h00, got);
        end
        repeat (2) @(posedge clk_i);
        check("irq after drain", 1'b0, irq);
        $display("test wake channel done");
        vld[2] <= 1'b0;
        host.wr(7'h06, 8'h80);
        fw_load(2, 16'h0001);
        check("async irq", 1'b0, irq);
        host.wr(7'h06, 8'h00);
        repeat (3) @(posedge clk_i);
        check("sync irq", 1'b1, irq);
        foreach (b[i]) if (i < 3) begin
            host.rd(7'h03, got);
            check("status read", (i == 0) ? 8'h01 : 8'h00, got);
        end
        check("underrun take", 3'h0, take);
        $display("test status channel done");
        b[2] = 8'h04;
        b[3] = 8'h00;
        foreach (b[i]) host.wr(7'h00, b[i]);
        @(posedge clk_i);
        check("fifo full", 1'b0, space);
        cready <= 1'b1;
        repeat (20) @(posedge clk_i);
        for (i = 0; i < 9; i++) check("cmd byte", {i == 0 || i == 8, b[i]}, rx[i]);
        check("cmd count", 16'd9, rx.size());
        $display("test command fifo done");
        end_sim();
    end
endmodule : test_hub_host_channels
